// [ebwc_bus.v]
// External memory bus with wait-state generator and ready handling
`timescale 1ns/1ps
`include "ebwc_consts.vh"
// Notes on behaviour
// - Read strobe low during off-chip reads.
// - Write strobe low during off-chip writes.
// - Access strobe low for whole access.
// - Direction output shows read or write.
// - Ready low: wait a cycle, resample.
// - Stall access and processing until ready.
// - Each wait state is one clock-out cycle.
// - Per-space configured wait states inserted.
// - Config register lives in I/O space.
// - Low program field for 0000h-7FFFh.
// - High program field for 8000h-FFFFh.
// - Program-select marks program accesses.
module ebwc_bus #(
  parameter AW = 16,
  parameter DW = 16,
  parameter WW = `EBWC_FIELD_W
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RST,
  // CPU request side
  input wire REQ,
  input wire REQ_WRITE,
  input wire [1:0] REQ_SPACE,
  input wire [AW-1:0] REQ_ADDR,
  input wire [DW-1:0] REQ_WDATA,
  output reg REQ_DONE,
  output reg [DW-1:0] REQ_RDATA,
  output reg CPU_STALL,
  // External bus
  output reg [AW-1:0] EXT_ADDR,
  output reg [DW-1:0] EXT_DATA_OUT,
  output reg EXT_DATA_OE,
  input wire [DW-1:0] EXT_DATA_IN,
  output reg READ_STROBE_N,
  output reg WRITE_STROBE_N,
  output reg EXTERNAL_ACCESS_STROBE_N,
  output reg READ_NOT_WRITE,
  output reg PROGRAM_SPACE_SELECT_N,
  output reg DATA_SPACE_SELECT_N,
  output reg IO_SPACE_SELECT_N,
  input wire READY,
  output reg MASTER_CLOCK_OUT,
  // Wait configuration view
  output reg [DW-1:0] WAIT_STATE_CONFIG_REG
);
  // ******************************
  // Local state
  // ******************************
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_READY = 2'h2;
  localparam ST_END = 2'h3;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`EBWC_CLK_HALF:0] div;
  reg tick;
  reg load;
  reg [WW-1:0] load_count;
  reg cur_write;
  reg cur_cfg;
  wire wait_done;

  // Wait field chosen by space and address
  function [WW-1:0] pick_wait;
    input [1:0] sp;
    input [AW-1:0] a;
    input [DW-1:0] cfg;
    begin
      case (sp)
        `EBWC_SP_PROG: begin
          if (a[`EBWC_PROG_HIGH_BIT])
            pick_wait = cfg[`EBWC_HPW_LSB +: WW];
          else
            pick_wait = cfg[`EBWC_LPW_LSB +: WW];
        end
        `EBWC_SP_DATA: pick_wait = cfg[`EBWC_DW_LSB +: WW];
        `EBWC_SP_IO: pick_wait = cfg[`EBWC_IOW_LSB +: WW];
        default: pick_wait = {WW{1'b0}};
      endcase
    end
  endfunction

  // ******************************
  // Master clock output divider
  // ******************************
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      div <= {(`EBWC_CLK_HALF+1){1'b0}};
      tick <= 1'b0;
      MASTER_CLOCK_OUT <= 1'b0;
    end else begin
      div <= div + {{`EBWC_CLK_HALF{1'b0}}, 1'b1};
      tick <= (div == {(`EBWC_CLK_HALF+1){1'b1}});
      if (div[`EBWC_CLK_HALF-1:0] == {`EBWC_CLK_HALF{1'b1}})
        MASTER_CLOCK_OUT <= ~MASTER_CLOCK_OUT;
    end
  end

  ebwc_wait_count #(
    .W(WW)
  ) u_count (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick),
    .load(load),
    .count_in(load_count),
    .done(wait_done)
  );

  // ******************************
  // Access sequencer
  // ******************************
  always @* begin
    next_state = state;
    load = 1'b0;
    load_count = pick_wait(REQ_SPACE, REQ_ADDR, WAIT_STATE_CONFIG_REG);
    case (state)
      ST_IDLE: begin
        if (REQ && tick) begin
          next_state = ST_WAIT;
          load = 1'b1;
        end
      end
      ST_WAIT: if (wait_done) next_state = ST_READY;
      ST_READY: if (tick && READY) next_state = ST_END;
      ST_END: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      cur_write <= 1'b0;
      cur_cfg <= 1'b0;
      CPU_STALL <= 1'b0;
      EXT_ADDR <= {AW{1'b0}};
      EXT_DATA_OUT <= {DW{1'b0}};
      EXT_DATA_OE <= 1'b0;
      READ_STROBE_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      EXTERNAL_ACCESS_STROBE_N <= 1'b1;
      READ_NOT_WRITE <= 1'b1;
      PROGRAM_SPACE_SELECT_N <= 1'b1;
      DATA_SPACE_SELECT_N <= 1'b1;
      IO_SPACE_SELECT_N <= 1'b1;
    end else begin
      state <= next_state;
      if (load) begin
        // Outputs latched once, held until the end state
        cur_write <= REQ_WRITE;
        cur_cfg <= (REQ_SPACE == `EBWC_SP_IO) && (REQ_ADDR == `EBWC_CFG_IO_ADDR);
        CPU_STALL <= 1'b1;
        EXT_ADDR <= REQ_ADDR;
        EXT_DATA_OUT <= REQ_WDATA;
        EXT_DATA_OE <= REQ_WRITE;
        READ_NOT_WRITE <= ~REQ_WRITE;
        READ_STROBE_N <= REQ_WRITE;
        WRITE_STROBE_N <= ~REQ_WRITE;
        EXTERNAL_ACCESS_STROBE_N <= 1'b0;
        PROGRAM_SPACE_SELECT_N <= (REQ_SPACE != `EBWC_SP_PROG);
        DATA_SPACE_SELECT_N <= (REQ_SPACE != `EBWC_SP_DATA);
        IO_SPACE_SELECT_N <= (REQ_SPACE != `EBWC_SP_IO);
      end else if (state == ST_END) begin
        CPU_STALL <= 1'b0;
        EXT_DATA_OE <= 1'b0;
        READ_STROBE_N <= 1'b1;
        WRITE_STROBE_N <= 1'b1;
        EXTERNAL_ACCESS_STROBE_N <= 1'b1;
        READ_NOT_WRITE <= 1'b1;
        PROGRAM_SPACE_SELECT_N <= 1'b1;
        DATA_SPACE_SELECT_N <= 1'b1;
        IO_SPACE_SELECT_N <= 1'b1;
      end
    end
  end

  // ******************************
  // Completion and read data
  // ******************************
  // Read data is taken while the strobes still stand
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REQ_DONE <= 1'b0;
      REQ_RDATA <= {DW{1'b0}};
    end else begin
      REQ_DONE <= (state == ST_END);
      if ((state == ST_END) && !cur_write) begin
        REQ_RDATA <= cur_cfg ? WAIT_STATE_CONFIG_REG : EXT_DATA_IN;
      end
    end
  end

  // ******************************
  // Wait-state configuration register
  // ******************************
  // Written only by an I/O write to its own address
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WAIT_STATE_CONFIG_REG <= `EBWC_CFG_RESET;
    end else if ((state == ST_END) && cur_cfg && cur_write) begin
      WAIT_STATE_CONFIG_REG <= EXT_DATA_OUT;
    end
  end
endmodule // ebwc_bus

// [ebwc_consts.vh]
// Constants for the external bus wait-control block
`ifndef EBWC_CONSTS_VH
`define EBWC_CONSTS_VH
// I/O address of the wait-state configuration register
`define EBWC_CFG_IO_ADDR 16'hFFFF
// Field positions in the configuration register
`define EBWC_LPW_LSB 0
`define EBWC_HPW_LSB 3
`define EBWC_DW_LSB 6
`define EBWC_IOW_LSB 9
`define EBWC_FIELD_W 3
// Reset value: most wait states everywhere
`define EBWC_CFG_RESET 16'h0FFF
// Program address split between low and high fields
`define EBWC_PROG_HIGH_BIT 15
// Space codes
`define EBWC_SP_PROG 2'h0
`define EBWC_SP_DATA 2'h1
`define EBWC_SP_IO 2'h2
// Master clock output divider (log2 of REF_CLK cycles per half period)
`define EBWC_CLK_HALF 1
`endif

// [ebwc_mem.sv]
// Model of the external memory with a ready line
`timescale 1ns/1ps
module ebwc_mem(
  input wire clk, rd_n, wr_n, slow,
  input wire [15:0] addr, wdata,
  output reg [15:0] rdata = 16'h5A5A,
  output reg ready = 1'h1);
  reg [15:0] m [0:15];
  reg [3:0] h = 4'h0;
  always @(posedge clk) begin
    if (!wr_n) m[addr[3:0]] <= wdata;
    rdata <= rd_n ? ~rdata : m[addr[3:0]];
    h <= rd_n & wr_n ? {slow, slow, 2'h0} : h - {3'h0, |h};
    ready <= rd_n & wr_n | ~|h;
  end
endmodule // ebwc_mem

// [ebwc_properties.sv]
// Checker for the external bus wait-control block
`timescale 1ns/1ps
module ebwc_properties(
  input wire REF_CLK, RST, CPU_STALL, READY, MASTER_CLOCK_OUT,
  input wire READ_STROBE_N, WRITE_STROBE_N, EXTERNAL_ACCESS_STROBE_N, READ_NOT_WRITE,
  input wire PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N,
  input wire [15:0] EXT_ADDR, WAIT_STATE_CONFIG_REG);
  wire s = EXTERNAL_ACCESS_STROBE_N;
  wire [15:0] c = WAIT_STATE_CONFIG_REG;
  wire [2:0] f = !DATA_SPACE_SELECT_N ? c[8:6] : !IO_SPACE_SELECT_N ? c[11:9] :
    EXT_ADDR[15] ? c[5:3] : c[2:0];
  reg [7:0] len;
  // Cycles the current access has been active
  always @(posedge REF_CLK or posedge RST)
    if (RST) len <= 8'h00;
    else len <= s ? 8'h00 : len + 8'h01;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence held; !s ##1 !s; endsequence
  a_read_strobe: assert property (!READ_STROBE_N |-> READ_NOT_WRITE && !s)
    else $error("read strobe");
  a_write_strobe: assert property (!WRITE_STROBE_N |-> !READ_NOT_WRITE && !s)
    else $error("write strobe");
  a_access_stall: assert property (!s |-> CPU_STALL && READ_STROBE_N != WRITE_STROBE_N)
    else $error("access strobe");
  a_ready_wait: assert property (!s && !READY && !$past(READY) |=> !s)
    else $error("ready ignored");
  a_access_stable: assert property (held |-> $stable(EXT_ADDR) && $stable(READ_NOT_WRITE))
    else $error("unstable access");
  a_prog_select: assert property (!PROGRAM_SPACE_SELECT_N |-> !s && DATA_SPACE_SELECT_N)
    else $error("program select");
  a_wait_count: assert property (!s && len < {3'h0, f, 2'h0} + 8'h01 |=> !s)
    else $error("access too short");
  a_clock_out: assert property ($changed(MASTER_CLOCK_OUT) |=> $stable(MASTER_CLOCK_OUT))
    else $error("clock out rate");
endmodule // ebwc_properties
bind ebwc_bus ebwc_properties chk(.*);

// [ebwc_wait_count.v]
// Wait-state countdown for one external access
`timescale 1ns/1ps
module ebwc_wait_count #(
  parameter W = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire tick,
  input wire load,
  input wire [W-1:0] count_in,
  // Status
  output reg done
);
  reg [W-1:0] remain;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      remain <= {W{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      remain <= count_in;
      done <= 1'b0;
    end else if (tick) begin
      if (remain != {W{1'b0}}) begin
        remain <= remain - {{(W-1){1'b0}}, 1'b1};
      end else begin
        done <= 1'b1;
      end
    end
  end
endmodule // ebwc_wait_count

// [test_external_bus_wait_control.sv]
// Testbench for the external bus wait-control block
`timescale 1ns/1ps
module test_external_bus_wait_control;
  reg REF_CLK = 0, RST = 1, REQ = 0, REQ_WRITE = 0, slow = 0, ps;
  reg [1:0] REQ_SPACE = 2'h0;
  reg [15:0] REQ_ADDR = 16'h0000, REQ_WDATA = 16'h0000, rd;
  wire [15:0] REQ_RDATA, EXT_ADDR, EXT_DATA_OUT, EXT_DATA_IN, WAIT_STATE_CONFIG_REG;
  wire REQ_DONE, CPU_STALL, EXT_DATA_OE, READ_STROBE_N, WRITE_STROBE_N, READY;
  wire EXTERNAL_ACCESS_STROBE_N, READ_NOT_WRITE, PROGRAM_SPACE_SELECT_N;
  wire DATA_SPACE_SELECT_N, IO_SPACE_SELECT_N, MASTER_CLOCK_OUT;
  integer fails = 0, samples_checked = 0, cyc, n, i, a, b;
  ebwc_bus dut(.*);
  ebwc_mem mem(.clk(REF_CLK), .rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N), .slow(slow),
    .addr(EXT_ADDR), .wdata(EXT_DATA_OUT), .rdata(EXT_DATA_IN), .ready(READY));
  initial forever #5 REF_CLK = ~REF_CLK;
  task summarize;
    begin
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task cmp(input ok, input [8*12:1] m);
    begin
      samples_checked = samples_checked + 1;
      if (!ok) begin
        fails = fails + 1;
        $display("BAD %0t %0s", $time, m);
      end
    end
  endtask
  // One access; counts stalled cycles
  task acc(input w, input [1:0] s, input [15:0] ad, input [15:0] d);
    begin
      REQ_WRITE = w; REQ_SPACE = s; REQ_ADDR = ad; REQ_WDATA = d; REQ = 1; cyc = 0;
      for (n = 0; n < 300 && REQ_DONE !== 1'h1; n = n + 1) begin
        @(negedge REF_CLK);
        if (CPU_STALL === 1'h1) begin
          cyc = cyc + 1; ps = PROGRAM_SPACE_SELECT_N;
        end
      end
      REQ = 0; rd = REQ_RDATA;
      if (n == 300) begin
        cmp(0, "timeout"); summarize;
      end
      @(negedge REF_CLK);
    end
  endtask
  task t_rw;
    for (i = 0; i < 3; i = i + 1) begin
      acc(1'h1, i[1:0], 16'h0001 + i[15:0], 16'h1234 + i[15:0]);
      acc(1'h0, i[1:0], 16'h0001 + i[15:0], 16'h0000);
      cmp(rd === 16'h1234 + i[15:0], "read back");
      cmp(ps === (i != 0), "prog select");
    end
  endtask
  task t_waits;
    begin
      acc(1'h0, 2'h1, 16'h0005, 16'h0000); a = cyc;
      cmp(WAIT_STATE_CONFIG_REG === 16'h0FFF, "config rst");
      acc(1'h1, 2'h2, 16'hFFFF, 16'h0E08);
      acc(1'h1, 2'h1, 16'hFFFF, 16'h0000);
      cmp(WAIT_STATE_CONFIG_REG === 16'h0E08, "config io");
      acc(1'h0, 2'h2, 16'hFFFF, 16'h0000);
      cmp(rd === 16'h0E08, "config read");
      acc(1'h0, 2'h1, 16'h0005, 16'h0000);
      cmp(a - cyc === 28, "data waits");
      acc(1'h0, 2'h0, 16'h0006, 16'h0000); a = cyc;
      acc(1'h0, 2'h0, 16'h8006, 16'h0000); b = cyc;
      cmp(b - a === 4, "prog waits");
    end
  endtask
  task t_ready;
    begin
      acc(1'h0, 2'h1, 16'h0002, 16'h0000); a = cyc;
      slow = 1;
      acc(1'h0, 2'h1, 16'h0002, 16'h0000);
      slow = 0;
      cmp(cyc >= a + 8, "ready stall");
      cmp(rd === 16'h1235, "slow read");
    end
  endtask
  task t_reset;
    begin
      RST = 1;
      repeat (2) @(negedge REF_CLK);
      cmp(EXTERNAL_ACCESS_STROBE_N === 1'h1 && CPU_STALL === 1'h0, "rst outputs");
      cmp(WAIT_STATE_CONFIG_REG === 16'h0FFF, "rst config");
      RST = 0;
      @(negedge REF_CLK);
      acc(1'h0, 2'h1, 16'h0002, 16'h0000);
      cmp(rd === 16'h1235, "rst read");
    end
  endtask
  initial begin
    repeat (4) @(negedge REF_CLK);
    RST = 0;
    @(negedge REF_CLK);
    t_rw; $display("t_rw ended");
    t_waits; $display("t_waits ended");
    t_ready; $display("t_ready ended");
    t_reset; $display("t_reset ended");
    summarize;
  end
endmodule // test_external_bus_wait_control
